// File: common/asim_pkg.sv
package asim_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] ASIM_IDX_ALARM = 8'h00;
    localparam logic [7:0] ASIM_IDX_MASK = 8'h01;
    localparam logic [7:0] ASIM_IDX_ISTAT = 8'h02;
    localparam logic [11:0] ASIM_ADDR_ALARM = 12'h000;
    localparam logic [11:0] ASIM_ADDR_MASK = 12'h004;
    localparam logic [11:0] ASIM_ADDR_ISTAT = 12'h008;
    localparam logic [11:0] ASIM_ADDR_IEN = 12'h00c;

    // Field positions
    localparam int ASIM_BIT_OVERCUR = 7;
    localparam int ASIM_BIT_OVERTEMP = 6;
    localparam int ASIM_BIT_ADC = 5;
    localparam int ASIM_BIT_OUT4 = 4;
    localparam int ASIM_BIT_OUT1 = 1;
    localparam int ASIM_BIT_GLOBAL = 0;
    localparam int ASIM_BIT_WDOG = 0;

    // Reset values
    localparam logic [7:0] ASIM_RST_ALARM = 8'h00;
    localparam logic [7:0] ASIM_RST_MASK = 8'h00;
    localparam logic [7:0] ASIM_RST_ISTAT = 8'h00;
    // Global enable comes up on, so after reset the mask alone gates interrupts
    localparam logic ASIM_RST_IEN = 1'b1;
    localparam logic [7:0] ASIM_MASK_WMASK = 8'hfe;

    typedef struct packed {
        logic overcur;
        logic overtemp;
        logic [3:0] out_fault;
        logic power_in_spec_pin;
        logic wdog_timeout;
    } asim_src_s;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } asim_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } asim_apb_rsp_s;

endpackage

// File: logic/asim_alarm_irq.sv
`timescale 1ns/100ps

module asim_alarm_irq #(
    parameter int ADC_W = 8,
    parameter int CUR_W = 5
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire asim_pkg::asim_apb_req_s apb_req_i,
    output asim_pkg::asim_apb_rsp_s apb_rsp_o,
    input wire asim_pkg::asim_src_s src_i,
    input wire logic [ADC_W-1:0] adc_value_i,
    input wire logic [ADC_W-1:0] adc_threshold_i,
    input wire logic [CUR_W-1:0] pd_current_i,
    input wire logic [CUR_W-1:0] overcur_threshold_i,
    output logic irq_o
);
    import asim_pkg::*;

    logic [7:0] alarm;
    logic [7:0] mask;
    logic [7:0] istat;
    logic ien;
    logic irq;
    asim_apb_rsp_s rsp;
    logic [7:0] next_alarm;
    logic [7:0] next_mask;
    logic [7:0] next_istat;
    logic next_ien;
    logic next_irq;
    asim_apb_rsp_s next_rsp;
    logic setup;
    logic wr_acc;
    logic rd_istat;

    // Answer in the first access cycle; pready is a flop so it rises one edge after setup
    assign setup = apb_req_i.psel && !apb_req_i.penable;
    assign wr_acc = apb_req_i.psel && apb_req_i.penable && rsp.pready && apb_req_i.pwrite;
    assign rd_istat = apb_req_i.psel && apb_req_i.penable && rsp.pready
        && !apb_req_i.pwrite && apb_req_i.paddr == ASIM_ADDR_ISTAT;

    always_comb
    begin
        next_alarm = '0;
        next_alarm[ASIM_BIT_OVERCUR] = pd_current_i > overcur_threshold_i;
        next_alarm[ASIM_BIT_OVERTEMP] = src_i.overtemp;
        next_alarm[ASIM_BIT_ADC] = adc_value_i > adc_threshold_i;
        next_alarm[ASIM_BIT_OUT4:ASIM_BIT_OUT1] = src_i.out_fault;
        // global fault follows the pin, which already excludes disabled outputs
        next_alarm[ASIM_BIT_GLOBAL] = !src_i.power_in_spec_pin;
        // Overcurrent source input kept for a comparator-free build; either asserts
        next_alarm[ASIM_BIT_OVERCUR] = next_alarm[ASIM_BIT_OVERCUR] | src_i.overcur;
    end

    always_comb
    begin
        next_mask = mask;
        next_ien = ien;
        // writes to the alarm register fall through untouched
        if (wr_acc && apb_req_i.paddr == ASIM_ADDR_MASK)
        begin
            next_mask = apb_req_i.pwdata[7:0] & ASIM_MASK_WMASK;
        end
        else if (wr_acc && apb_req_i.paddr == ASIM_ADDR_IEN)
        begin
            next_ien = apb_req_i.pwdata[0];
        end
    end

    always_comb
    begin
        next_istat = istat;
        // Clear on read; new events in the same cycle still land
        if (rd_istat)
        begin
            next_istat = '0;
        end
        // sticky latch of the source conditions
        next_istat[7:1] = next_istat[7:1] | alarm[7:1];
        next_istat[ASIM_BIT_WDOG] = next_istat[ASIM_BIT_WDOG] | src_i.wdog_timeout;
    end

    always_comb
    begin
        next_irq = next_ien && |(next_istat[7:1] & next_mask[7:1]);
    end

    always_comb
    begin
        next_rsp = '0;
        next_rsp.pready = setup;
        if (setup && !apb_req_i.pwrite)
        begin
            if (apb_req_i.paddr == ASIM_ADDR_ALARM)
            begin
                next_rsp.prdata = {24'h000000, alarm};
            end
            else if (apb_req_i.paddr == ASIM_ADDR_MASK)
            begin
                next_rsp.prdata = {24'h000000, mask};
            end
            else if (apb_req_i.paddr == ASIM_ADDR_ISTAT)
            begin
                // events landing now are shown, as the access-edge clear drops them
                next_rsp.prdata = {24'h000000, next_istat};
            end
            else if (apb_req_i.paddr == ASIM_ADDR_IEN)
            begin
                next_rsp.prdata = {31'h00000000, ien};
            end
            else
            begin
                next_rsp.pslverr = setup;
            end
        end
        else if (setup && apb_req_i.paddr != ASIM_ADDR_ALARM
            && apb_req_i.paddr != ASIM_ADDR_MASK && apb_req_i.paddr != ASIM_ADDR_ISTAT
            && apb_req_i.paddr != ASIM_ADDR_IEN)
        begin
            next_rsp.pslverr = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            alarm <= ASIM_RST_ALARM;
        end
        else
        begin
            alarm <= next_alarm;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mask <= ASIM_RST_MASK;
            ien <= ASIM_RST_IEN;
        end
        else
        begin
            mask <= next_mask;
            ien <= next_ien;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            istat <= ASIM_RST_ISTAT;
        end
        else
        begin
            istat <= next_istat;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= next_irq;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rsp <= '0;
        end
        else
        begin
            rsp <= next_rsp;
        end
    end

    assign apb_rsp_o = rsp;
    assign irq_o = irq;

    // Guards on resetn_i skip the release edge, where flops still hold reset values

    chk_alarm_ro: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i |=> alarm == $past(next_alarm))
        else $error("alarm register did not follow sources");

    chk_alarm_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !$past(resetn_i) |-> alarm == ASIM_RST_ALARM)
        else $error("alarm register not cleared by reset");

    chk_alarm_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i && setup && !apb_req_i.pwrite && apb_req_i.paddr == ASIM_ADDR_ALARM
        |=> rsp.pready && rsp.prdata == {24'h000000, $past(alarm)})
        else $error("alarm read returned wrong data");

    chk_overcur_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i && pd_current_i > overcur_threshold_i |=> alarm[ASIM_BIT_OVERCUR])
        else $error("over-current alarm not raised");

    chk_overcur_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pd_current_i <= overcur_threshold_i && !src_i.overcur |=> !alarm[ASIM_BIT_OVERCUR])
        else $error("over-current alarm without cause");

    chk_temp_track: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i |=> alarm[ASIM_BIT_OVERTEMP] == $past(src_i.overtemp))
        else $error("over-temperature bit does not track");

    chk_adc_strict: assert property (@(posedge clk_i) disable iff (!resetn_i)
        adc_value_i == adc_threshold_i |=> !alarm[ASIM_BIT_ADC])
        else $error("equal reading raised converter alarm");

    chk_adc_above: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i && adc_value_i > adc_threshold_i |=> alarm[ASIM_BIT_ADC])
        else $error("converter alarm not raised");

    chk_global_pin: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i |=> alarm[ASIM_BIT_GLOBAL] == !$past(src_i.power_in_spec_pin))
        else $error("global fault does not mirror pin");

    chk_out_track: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i |=> alarm[ASIM_BIT_OUT4:ASIM_BIT_OUT1] == $past(src_i.out_fault))
        else $error("output fault bits do not track");

    chk_out1_track: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i |=> alarm[ASIM_BIT_OUT1] == $past(src_i.out_fault[0]))
        else $error("output one fault bit does not track");

    chk_mask_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !$past(resetn_i) |-> mask == ASIM_RST_MASK && ien == ASIM_RST_IEN)
        else $error("mask not cleared by reset");

    chk_mask_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_acc && apb_req_i.paddr == ASIM_ADDR_MASK
        |=> mask == ($past(apb_req_i.pwdata[7:0]) & ASIM_MASK_WMASK))
        else $error("mask write lost");

    chk_mask_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i && !(wr_acc && apb_req_i.paddr == ASIM_ADDR_MASK) |=> $stable(mask))
        else $error("mask changed without a write");

    chk_mask_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i && setup && !apb_req_i.pwrite && apb_req_i.paddr == ASIM_ADDR_MASK
        |=> rsp.pready && rsp.prdata == {24'h000000, $past(mask)})
        else $error("mask read returned wrong data");

    chk_mask_rsvd: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !mask[0])
        else $error("reserved mask bit set");

    sequence s_src_seen;
        alarm[ASIM_BIT_OUT1] && !rd_istat;
    endsequence

    sequence s_istat_setup;
        resetn_i && setup && !apb_req_i.pwrite && apb_req_i.paddr == ASIM_ADDR_ISTAT;
    endsequence

    sequence s_istat_access;
        s_istat_setup ##1 rd_istat;
    endsequence

    chk_istat_latch: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_src_seen |=> istat[ASIM_BIT_OUT1])
        else $error("interrupt status did not latch");

    chk_istat_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i && !rd_istat |=> (istat & $past(istat)) == $past(istat))
        else $error("interrupt status bit lost without a read");

    chk_istat_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_istat_access |=> istat == {$past(alarm[7:1]), $past(src_i.wdog_timeout)})
        else $error("interrupt status not cleared by read");

    chk_istat_snapshot: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_istat_setup |=> rsp.prdata[7:0]
            == ($past(istat) | {$past(alarm[7:1]), $past(src_i.wdog_timeout)}))
        else $error("interrupt status read missed an event");

    chk_wdog_latch: assert property (@(posedge clk_i) disable iff (!resetn_i)
        resetn_i && src_i.wdog_timeout |=> istat[ASIM_BIT_WDOG])
        else $error("watchdog timeout not latched");

    chk_wdog_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !$past(resetn_i) |-> istat == ASIM_RST_ISTAT)
        else $error("interrupt status not cleared by reset");

    chk_irq_masked: assert property (@(posedge clk_i) disable iff (!resetn_i)
        mask[7:1] == 7'h00 |-> !irq)
        else $error("interrupt with every source masked");

    chk_irq_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
        irq == (ien && |(istat[7:1] & mask[7:1])))
        else $error("interrupt does not match unmasked sources");

endmodule // asim_alarm_irq

// File: tb/alarm_status_interrupt_mask_tb.sv
`timescale 1ns/100ps
module alarm_status_interrupt_mask_tb;
    import asim_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    asim_apb_req_s req = '0;
    asim_apb_rsp_s rsp;
    asim_src_s src = 8'h02;
    logic [7:0] adc = 8'h00;
    logic [7:0] ath = 8'h00;
    logic [4:0] cur = 5'h00;
    logic [4:0] cth = 5'h00;
    logic irq_o;
    logic [32:0] exp_q[$];
    int n_errors = 0;
    int check_count = 0;
    logic [7:0] a, t, m, al, prev_al;
    logic [4:0] c, h;
    logic prev_wd;
    asim_src_s s;

    asim_alarm_irq asim_alarm_irq_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .apb_req_i(req), .apb_rsp_o(rsp),
        .src_i(src), .adc_value_i(adc), .adc_threshold_i(ath), .pd_current_i(cur),
        .overcur_threshold_i(cth), .irq_o(irq_o));

    always #2.5 clk_i = ~clk_i;

    task chk(input string n, input logic [32:0] e, input logic [32:0] v);
        check_count++;
        if (v !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, v);
        end
    endtask

    // Reads leave a note of the expected {pslverr, prdata} for the monitor
    task apb(input logic [11:0] ad, input logic w, input logic [31:0] d, input logic [32:0] e);
        if (!w)
            exp_q.push_back(e);
        req.paddr <= ad;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        @(posedge clk_i);
        req.penable <= 1'b1;
        do @(posedge clk_i); while (rsp.pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk_i);
    endtask

    task report_and_stop();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        if (rsp.pready === 1'b1 && req.pwrite === 1'b0)
            chk("read data", exp_q.pop_front(), {rsp.pslverr, rsp.prdata});
    end

    // Twenty-four iterations of about twelve cycles each fit well inside this span
    initial
    begin
        #20000;
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'h4d47b09c));
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        chk("irq", 33'h0, {32'h0, irq_o});
        apb(ASIM_ADDR_ALARM, 1'b0, 32'h0, 33'h0);
        apb(ASIM_ADDR_MASK, 1'b0, 32'h0, 33'h0);
        apb(ASIM_ADDR_ISTAT, 1'b0, 32'h0, 33'h0);
        apb(ASIM_ADDR_ALARM, 1'b1, 32'hff, 33'h0);
        apb(ASIM_ADDR_ALARM, 1'b0, 32'h0, 33'h0);
        apb(ASIM_ADDR_MASK, 1'b1, 32'hfe, 33'h0);
        apb(ASIM_ADDR_MASK, 1'b0, 32'h0, 33'h0fe);
        apb(12'h010, 1'b0, 32'h0, {1'b1, 32'h0});
        apb(ASIM_ADDR_IEN, 1'b0, 32'h0, 33'h1);
        prev_al = 8'h00;
        prev_wd = 1'b0;
        repeat (24)
        begin
            // Equal operands now and then probe the strict comparisons
            a = 8'($urandom);
            t = ($urandom % 4 == 0) ? a : 8'($urandom);
            c = 5'($urandom);
            h = ($urandom % 4 == 0) ? c : 5'($urandom);
            s = asim_src_s'(8'($urandom));
            s.overcur = ($urandom % 4 == 0);
            m = {7'($urandom), 1'b0};
            adc <= a;
            ath <= t;
            cur <= c;
            cth <= h;
            src <= s;
            al = {(c > h) | s.overcur, s.overtemp, a > t, s.out_fault, ~s.power_in_spec_pin};
            apb(ASIM_ADDR_MASK, 1'b1, {24'h0, m}, 33'h0);
            apb(ASIM_ADDR_ALARM, 1'b0, 32'h0, {25'h0, al});
            chk("irq", {32'h0, |((prev_al | al) & m)}, {32'h0, irq_o});
            apb(ASIM_ADDR_ISTAT, 1'b0, 32'h0,
                {25'h0, ((prev_al | al) & 8'hfe) | {7'h0, prev_wd | s.wdog_timeout}});
            repeat (3) @(posedge clk_i);
            chk("irq", {32'h0, |(al & m)}, {32'h0, irq_o});
            prev_al = al;
            prev_wd = s.wdog_timeout;
        end
        report_and_stop();
    end
endmodule // alarm_status_interrupt_mask_tb
